/* design/pjt_pkg.sv */
// Shared constants and types for the pulser/jog-teach interlock ends
package pjt_pkg;
   localparam int AW = 13;
   localparam int DW = 16;
   // Buffer-memory word addresses
   localparam logic [12:0] ADR_EN_X = 13'h002F;
   localparam logic [12:0] ADR_EN_Y = 13'h015B;
   localparam logic [12:0] ADR_RATE_X = 13'h00CA;
   localparam logic [12:0] ADR_RATE_Y = 13'h01F6;
   localparam logic [12:0] ADR_JOG_X = 13'h002C;
   localparam logic [12:0] ADR_JOG_Y = 13'h0158;
   localparam logic [12:0] ADR_JOG_LIM = 13'h03E0;
   localparam logic [12:0] ADR_ERR = 13'h03E1;
   localparam logic [12:0] ADR_DATA_X = 13'h13D0;
   localparam logic [12:0] ADR_DATA_Y = 13'h1600;
   localparam logic [15:0] EN_ON = 16'h0001;
   localparam logic [15:0] EN_OFF = 16'h0000;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] RST_JOG_LIM = 16'hFFFF;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_PULSER_BUSY = 8'h49;
   // Output rate word counts in 10 pulses/s
   localparam int CLK_HZ = 40000000;
   localparam int RATE_UNIT_PPS = 10;
   localparam logic [22:0] NCO_TOP = 23'(CLK_HZ / RATE_UNIT_PPS);
   localparam logic [23:0] PEND_MAX = 24'hFFFFFF;
   typedef enum logic [2:0] {
      CMD_SETUP,
      CMD_INCH_ON,
      CMD_INCH_OFF,
      CMD_JOG,
      CMD_STORE
   } pjt_cmd_t;
   function automatic logic [12:0] pjt_axis_adr(input logic ax, input logic [12:0] ax_x,
                                                input logic [12:0] ax_y);
      pjt_axis_adr = ax ? ax_y : ax_x;
   endfunction : pjt_axis_adr
endpackage : pjt_pkg

/* design/pjt_if.sv */
// Interface joining the positioning module end and the controller end
`timescale 1ns/10ps
`default_nettype none
interface pjt_if;
   logic module_ready_flag;
   logic x_axis_busy_flag;
   logic y_axis_busy_flag;
   logic x_positioning_started_flag;
   logic y_positioning_started_flag;
   logic x_aux_code_active_flag;
   logic y_aux_code_active_flag;
   logic x_axis_stop_request;
   logic y_axis_stop_request;
   logic host_ready_request;
   logic bm_wr;
   logic bm_rd;
   logic [12:0] bm_addr;
   logic [15:0] bm_wdata;
   logic [15:0] bm_rdata;
   logic bm_rvalid;
   modport dev (
      output module_ready_flag, x_axis_busy_flag, y_axis_busy_flag,
      output x_positioning_started_flag, y_positioning_started_flag,
      output x_aux_code_active_flag, y_aux_code_active_flag, bm_rdata, bm_rvalid,
      input x_axis_stop_request, y_axis_stop_request, host_ready_request,
      input bm_wr, bm_rd, bm_addr, bm_wdata
   );
   modport host (
      input module_ready_flag, x_axis_busy_flag, y_axis_busy_flag,
      input x_positioning_started_flag, y_positioning_started_flag,
      input x_aux_code_active_flag, y_aux_code_active_flag, bm_rdata, bm_rvalid,
      output x_axis_stop_request, y_axis_stop_request, host_ready_request,
      output bm_wr, bm_rd, bm_addr, bm_wdata
   );
endinterface : pjt_if
`default_nettype wire

/* design/pjt_dev.sv */
// Positioning module end: pulser counting, pulse output, busy and error flags
`timescale 1ns/10ps
`default_nettype none
module pjt_dev (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   pjt_if.dev bus,
   input wire logic [1:0] pulser_pulse_i,
   input wire logic [1:0] motion_busy_i,
   input wire logic [1:0] pos_started_i,
   input wire logic [1:0] aux_active_i,
   output var logic [1:0] step_o,
   output var logic [1:0][15:0] jog_speed_o,
   output var logic [7:0] err_code_o
);
   typedef struct packed {
      logic [1:0][1:0] psync;
      logic [1:0] pprev;
      logic [1:0][15:0] en;
      logic [1:0][15:0] rate;
      logic [1:0][15:0] jog;
      logic [15:0] jog_lim;
      logic [7:0] err;
      logic [1:0][23:0] pend;
      logic [1:0][22:0] acc;
      logic [1:0] step;
      logic [1:0] busy;
      logic [1:0] started;
      logic [1:0] aux;
      logic ready;
      logic [15:0] rdata;
      logic rvalid;
      logic [1:0][15:0] jog_out;
   } pjt_dev_st_t;

   pjt_dev_st_t st_r;
   pjt_dev_st_t st_nxt;
   logic [1:0] stop_req;
   logic [23:0] acc_sum;
   logic edge_in;

   assign stop_req = {bus.y_axis_stop_request, bus.x_axis_stop_request};

   always_comb begin
      st_nxt = st_r;
      acc_sum = 24'h000000;
      edge_in = 1'b0;
      st_nxt.ready = 1'b1;
      st_nxt.rvalid = 1'b0;
      st_nxt.started = pos_started_i;
      st_nxt.aux = aux_active_i;
      if (bus.bm_wr) begin
         case (bus.bm_addr)
            pjt_pkg::ADR_EN_X: st_nxt.en[0] = bus.bm_wdata;
            pjt_pkg::ADR_EN_Y: st_nxt.en[1] = bus.bm_wdata;
            pjt_pkg::ADR_RATE_X: st_nxt.rate[0] = bus.bm_wdata;
            pjt_pkg::ADR_RATE_Y: st_nxt.rate[1] = bus.bm_wdata;
            pjt_pkg::ADR_JOG_X: st_nxt.jog[0] = bus.bm_wdata;
            pjt_pkg::ADR_JOG_Y: st_nxt.jog[1] = bus.bm_wdata;
            pjt_pkg::ADR_JOG_LIM: st_nxt.jog_lim = bus.bm_wdata;
            pjt_pkg::ADR_ERR: st_nxt.err = pjt_pkg::ERR_NONE;
            default: ;
         endcase
      end
      if (bus.bm_rd) begin
         st_nxt.rvalid = 1'b1;
         case (bus.bm_addr)
            pjt_pkg::ADR_EN_X: st_nxt.rdata = st_r.en[0];
            pjt_pkg::ADR_EN_Y: st_nxt.rdata = st_r.en[1];
            pjt_pkg::ADR_RATE_X: st_nxt.rdata = st_r.rate[0];
            pjt_pkg::ADR_RATE_Y: st_nxt.rdata = st_r.rate[1];
            pjt_pkg::ADR_JOG_X: st_nxt.rdata = st_r.jog[0];
            pjt_pkg::ADR_JOG_Y: st_nxt.rdata = st_r.jog[1];
            pjt_pkg::ADR_JOG_LIM: st_nxt.rdata = st_r.jog_lim;
            pjt_pkg::ADR_ERR: st_nxt.rdata = {8'h00, st_r.err};
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
      for (int a = 0; a < 2; a++) begin
         st_nxt.psync[a] = {st_r.psync[a][0], pulser_pulse_i[a]};
         st_nxt.pprev[a] = st_r.psync[a][1];
         edge_in = st_r.psync[a][1] & ~st_r.pprev[a];
         // Requested speed above the limit runs at the limit
         st_nxt.jog_out[a] = (st_r.jog[a] > st_r.jog_lim) ? st_r.jog_lim : st_r.jog[a];
         st_nxt.step[a] = 1'b0;
         if (edge_in && st_r.en[a] == pjt_pkg::EN_ON) begin
            if (motion_busy_i[a]) begin
               st_nxt.err = pjt_pkg::ERR_PULSER_BUSY;
            end else if (st_r.pend[a] != pjt_pkg::PEND_MAX) begin
               // Pulses past the counter ceiling are dropped, not wrapped
               st_nxt.pend[a] = st_r.pend[a] + 24'h000001;
            end
         end
         // Zero enable ignores input silently and flushes what was counted
         if (st_r.en[a] != pjt_pkg::EN_ON || stop_req[a]) begin
            st_nxt.pend[a] = 24'h000000;
            st_nxt.acc[a] = 23'h000000;
         end else if (st_r.pend[a] != 24'h000000) begin
            acc_sum = {1'b0, st_r.acc[a]} + {8'h00, st_r.rate[a]};
            if (acc_sum >= {1'b0, pjt_pkg::NCO_TOP}) begin
               st_nxt.acc[a] = 23'(acc_sum - {1'b0, pjt_pkg::NCO_TOP});
               st_nxt.step[a] = 1'b1;
               st_nxt.pend[a] = st_nxt.pend[a] - 24'h000001;
            end else begin
               st_nxt.acc[a] = acc_sum[22:0];
            end
         end
         st_nxt.busy[a] = motion_busy_i[a] | (st_nxt.pend[a] != 24'h000000);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.jog_lim <= pjt_pkg::RST_JOG_LIM;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.module_ready_flag = st_r.ready;
   assign bus.x_axis_busy_flag = st_r.busy[0];
   assign bus.y_axis_busy_flag = st_r.busy[1];
   assign bus.x_positioning_started_flag = st_r.started[0];
   assign bus.y_positioning_started_flag = st_r.started[1];
   assign bus.x_aux_code_active_flag = st_r.aux[0];
   assign bus.y_aux_code_active_flag = st_r.aux[1];
   assign bus.bm_rdata = st_r.rdata;
   assign bus.bm_rvalid = st_r.rvalid;
   assign step_o = st_r.step;
   assign jog_speed_o = st_r.jog_out;
   assign err_code_o = st_r.err;
endmodule : pjt_dev
`default_nettype wire

/* design/pjt_host.sv */
// Controller end: start-condition checks and buffer-memory write sequences
//
// Contract
// - Inching start needs axis not busy.
// - Module holds busy while emitting pulser pulses.
// - Start needs positioning-started flag off.
// - Start needs auxiliary code flag off.
// - Start needs axis stop request off.
// - Enable bit zero ignores pulser silently.
// - Load output rate word before enabling.
// - Pulser during other motion raises error 73.
// - Clear enable word when not inching.
// - After halt, both axes idle first.
// - Test mode skips ready flag checks.
// - Jog speed at least bias; clamped above limit.
// - Jog teach stores position into data entry.
// - Inching teach stores reached position.
// - Combined teach: jog, inch, then store.
// - Jog teach after halt needs both idle.
// - Pulses counted only when enabled, not otherwise busy.
`timescale 1ns/10ps
`default_nettype none
module pjt_host (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   pjt_if.host bus,
   input wire logic cmd_valid_i,
   input wire pjt_pkg::pjt_cmd_t cmd_i,
   input wire logic axis_i,
   input wire logic [15:0] arg_i,
   input wire logic [31:0] pos_i,
   input wire logic [7:0] data_no_i,
   input wire logic [15:0] bias_i,
   input wire logic test_mode_i,
   input wire logic halt_seen_i,
   input wire logic [1:0] stop_i,
   input wire logic drive_ready_i,
   input wire logic ext_stop_i,
   output var logic cmd_ready_o,
   output var logic done_o,
   output var logic refused_o
);
   typedef enum logic [3:0] {
      HS_IDLE,
      HS_CHECK,
      HS_DROP,
      HS_RATE,
      HS_RAISE,
      HS_EN,
      HS_OFF,
      HS_JOG,
      HS_LO,
      HS_HI,
      HS_SETUP
   } pjt_hst_t;

   typedef struct packed {
      pjt_hst_t fsm;
      logic [1:0] dsync;
      logic [1:0] esync;
      logic [1:0] stop;
      logic hready;
      logic wr;
      logic [12:0] addr;
      logic [15:0] wdata;
      logic idle;
      logic done;
      logic refused;
      pjt_pkg::pjt_cmd_t cmd;
      logic ax;
      logic [15:0] arg;
      logic [31:0] pos;
      logic [7:0] no;
   } pjt_host_st_t;

   pjt_host_st_t st_r;
   pjt_host_st_t st_nxt;
   logic [1:0] busy;
   logic [1:0] started;
   logic [1:0] aux;

   assign busy = {bus.y_axis_busy_flag, bus.x_axis_busy_flag};
   assign started = {bus.y_positioning_started_flag, bus.x_positioning_started_flag};
   assign aux = {bus.y_aux_code_active_flag, bus.x_aux_code_active_flag};

   // Common start interlock for inching and jog-teach
   function automatic logic start_ok(input pjt_host_st_t s, input logic [1:0] bz,
                                     input logic [1:0] sf, input logic [1:0] af,
                                     input logic mrdy, input logic tst, input logic halt);
      logic ok;
      ok = s.dsync[1] & ~s.esync[1];
      ok = ok & ~bz[s.ax];
      ok = ok & ~sf[s.ax];
      ok = ok & ~af[s.ax];
      ok = ok & ~s.stop[s.ax];
      // Test mode may leave these off, so they are not looked at
      ok = ok & (tst | (mrdy & s.hready));
      // After a peripheral halt both axes must be at rest
      ok = ok & (~halt | (bz == 2'b00));
      start_ok = ok;
   endfunction : start_ok

   function automatic logic [12:0] data_adr(input logic ax, input logic [7:0] no,
                                            input logic hi);
      data_adr = pjt_pkg::pjt_axis_adr(ax, pjt_pkg::ADR_DATA_X, pjt_pkg::ADR_DATA_Y)
                 + {4'h0, no, hi};
   endfunction : data_adr

   always_comb begin
      st_nxt = st_r;
      st_nxt.dsync = {st_r.dsync[0], drive_ready_i};
      st_nxt.esync = {st_r.esync[0], ext_stop_i};
      st_nxt.stop = stop_i;
      st_nxt.wr = 1'b0;
      st_nxt.done = 1'b0;
      st_nxt.refused = 1'b0;
      st_nxt.idle = 1'b0;
      case (st_r.fsm)
         HS_IDLE: begin
            st_nxt.idle = 1'b1;
            if (cmd_valid_i) begin
               st_nxt.idle = 1'b0;
               st_nxt.cmd = cmd_i;
               st_nxt.ax = axis_i;
               st_nxt.arg = arg_i;
               st_nxt.pos = pos_i;
               st_nxt.no = data_no_i;
               st_nxt.fsm = HS_CHECK;
            end
         end
         HS_CHECK: begin
            st_nxt.fsm = HS_IDLE;
            st_nxt.refused = 1'b1;
            case (st_r.cmd)
               pjt_pkg::CMD_SETUP: begin
                  st_nxt.refused = 1'b0;
                  st_nxt.fsm = HS_SETUP;
               end
               pjt_pkg::CMD_INCH_OFF: begin
                  st_nxt.refused = 1'b0;
                  st_nxt.fsm = HS_OFF;
               end
               pjt_pkg::CMD_INCH_ON: begin
                  if (start_ok(st_r, busy, started, aux, bus.module_ready_flag,
                               test_mode_i, halt_seen_i)) begin
                     st_nxt.refused = 1'b0;
                     st_nxt.fsm = HS_DROP;
                  end
               end
               pjt_pkg::CMD_JOG: begin
                  if (start_ok(st_r, busy, started, aux, bus.module_ready_flag,
                               test_mode_i, halt_seen_i) && st_r.arg >= bias_i) begin
                     st_nxt.refused = 1'b0;
                     st_nxt.fsm = HS_JOG;
                  end
               end
               pjt_pkg::CMD_STORE: begin
                  // Position is only final once the axis has come to rest
                  if (!busy[st_r.ax]) begin
                     st_nxt.refused = 1'b0;
                     st_nxt.fsm = HS_LO;
                  end
               end
               default: ;
            endcase
            st_nxt.idle = st_nxt.refused;
         end
         HS_SETUP: begin
            st_nxt.wr = 1'b1;
            st_nxt.addr = pjt_pkg::ADR_JOG_LIM;
            st_nxt.wdata = st_r.arg;
            st_nxt.hready = 1'b1;
            st_nxt.done = 1'b1;
            st_nxt.idle = 1'b1;
            st_nxt.fsm = HS_IDLE;
         end
         HS_DROP: begin
            st_nxt.hready = 1'b0;
            st_nxt.fsm = HS_RATE;
         end
         HS_RATE: begin
            st_nxt.wr = 1'b1;
            st_nxt.addr = pjt_pkg::pjt_axis_adr(st_r.ax, pjt_pkg::ADR_RATE_X,
                                                pjt_pkg::ADR_RATE_Y);
            st_nxt.wdata = st_r.arg;
            st_nxt.fsm = HS_RAISE;
         end
         HS_RAISE: begin
            st_nxt.hready = 1'b1;
            st_nxt.fsm = HS_EN;
         end
         HS_EN: begin
            st_nxt.wr = 1'b1;
            st_nxt.addr = pjt_pkg::pjt_axis_adr(st_r.ax, pjt_pkg::ADR_EN_X, pjt_pkg::ADR_EN_Y);
            st_nxt.wdata = pjt_pkg::EN_ON;
            st_nxt.done = 1'b1;
            st_nxt.idle = 1'b1;
            st_nxt.fsm = HS_IDLE;
         end
         HS_OFF: begin
            st_nxt.wr = 1'b1;
            st_nxt.addr = pjt_pkg::pjt_axis_adr(st_r.ax, pjt_pkg::ADR_EN_X, pjt_pkg::ADR_EN_Y);
            st_nxt.wdata = pjt_pkg::EN_OFF;
            st_nxt.done = 1'b1;
            st_nxt.idle = 1'b1;
            st_nxt.fsm = HS_IDLE;
         end
         HS_JOG: begin
            st_nxt.wr = 1'b1;
            st_nxt.addr = pjt_pkg::pjt_axis_adr(st_r.ax, pjt_pkg::ADR_JOG_X, pjt_pkg::ADR_JOG_Y);
            st_nxt.wdata = st_r.arg;
            st_nxt.done = 1'b1;
            st_nxt.idle = 1'b1;
            st_nxt.fsm = HS_IDLE;
         end
         HS_LO: begin
            st_nxt.wr = 1'b1;
            st_nxt.addr = data_adr(st_r.ax, st_r.no, 1'b0);
            st_nxt.wdata = st_r.pos[15:0];
            st_nxt.fsm = HS_HI;
         end
         HS_HI: begin
            st_nxt.wr = 1'b1;
            st_nxt.addr = data_adr(st_r.ax, st_r.no, 1'b1);
            st_nxt.wdata = st_r.pos[31:16];
            st_nxt.done = 1'b1;
            st_nxt.idle = 1'b1;
            st_nxt.fsm = HS_IDLE;
         end
         default: begin
            st_nxt.fsm = HS_IDLE;
            st_nxt.idle = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.fsm <= HS_IDLE;
         st_r.idle <= 1'b1;
         st_r.cmd <= pjt_pkg::CMD_SETUP;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.x_axis_stop_request = st_r.stop[0];
   assign bus.y_axis_stop_request = st_r.stop[1];
   assign bus.host_ready_request = st_r.hready;
   assign bus.bm_wr = st_r.wr;
   assign bus.bm_rd = 1'b0;
   assign bus.bm_addr = st_r.addr;
   assign bus.bm_wdata = st_r.wdata;
   assign cmd_ready_o = st_r.idle;
   assign done_o = st_r.done;
   assign refused_o = st_r.refused;
endmodule : pjt_host
`default_nettype wire

/* test/pjt_monitor.sv */
// Interface checks for the pulser/jog-teach link between the two ends
`timescale 1ns/10ps
`default_nettype none
module pjt_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic module_ready_flag,
   input wire logic x_axis_busy_flag,
   input wire logic x_positioning_started_flag,
   input wire logic x_aux_code_active_flag,
   input wire logic x_axis_stop_request,
   input wire logic host_ready_request,
   input wire logic bm_wr,
   input wire logic [12:0] bm_addr,
   input wire logic [15:0] bm_wdata
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   logic en_x_on;
   logic store_x;
   assign en_x_on = bm_wr && bm_addr == pjt_pkg::ADR_EN_X && bm_wdata == pjt_pkg::EN_ON;
   assign store_x = bm_wr && bm_addr >= pjt_pkg::ADR_DATA_X && bm_addr < pjt_pkg::ADR_DATA_Y;
   a_inch_not_busy: assert property (en_x_on |-> !x_axis_busy_flag)
      else $error("enable written while axis busy");
   a_inch_not_started: assert property (en_x_on |-> !x_positioning_started_flag)
      else $error("enable written while positioning started");
   a_inch_no_aux: assert property (en_x_on |-> !x_aux_code_active_flag)
      else $error("enable written while aux code active");
   a_inch_no_stop: assert property (en_x_on |-> !x_axis_stop_request)
      else $error("enable written while stop requested");
   a_rate_before_enable: assert property (en_x_on |->
      $past(bm_wr, 2) && $past(bm_addr, 2) == pjt_pkg::ADR_RATE_X)
      else $error("rate word not written two cycles before enable");
   a_ready_at_enable: assert property (en_x_on |->
      host_ready_request && module_ready_flag)
      else $error("enable written without ready handshake");
   a_store_word_pair: assert property (store_x && !bm_addr[0] |=>
      bm_wr && bm_addr == $past(bm_addr) + 13'h0001)
      else $error("position high word does not follow low word");
   a_store_not_busy: assert property (store_x |-> !x_axis_busy_flag)
      else $error("position stored while axis busy");
endmodule : pjt_monitor
`default_nettype wire

/* test/pulser_jog_teach_interlock_tb_top.sv */
// Self-checking bench joining controller end and module end
`timescale 1ns/10ps
`default_nettype none
module pulser_jog_teach_interlock_tb_top;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cmd_valid = 1'b0;
   pjt_pkg::pjt_cmd_t cmd = pjt_pkg::CMD_SETUP;
   logic [15:0] arg = 16'h0000;
   logic [15:0] bias = 16'h0020;
   logic [1:0] stop = 2'h0;
   logic drive_ready = 1'b1;
   logic ext_stop = 1'b0;
   logic test_mode = 1'b0;
   logic halt_seen = 1'b0;
   logic [1:0] pulser = 2'h0;
   logic [1:0] motion_busy = 2'h0;
   logic [1:0] pos_started = 2'h0;
   logic [1:0] aux = 2'h0;
   logic cmd_ready;
   logic done;
   logic refused;
   logic [1:0] step;
   logic [1:0][15:0] jog_speed;
   logic [7:0] err;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;

   pjt_if u_pjt_if ();
   pjt_dev u_pjt_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(u_pjt_if),
      .pulser_pulse_i(pulser), .motion_busy_i(motion_busy), .pos_started_i(pos_started),
      .aux_active_i(aux), .step_o(step), .jog_speed_o(jog_speed), .err_code_o(err));
   pjt_host u_pjt_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(u_pjt_if),
      .cmd_valid_i(cmd_valid), .cmd_i(cmd), .axis_i(1'b0), .arg_i(arg),
      .pos_i(32'h12345678), .data_no_i(8'h03), .bias_i(bias), .test_mode_i(test_mode),
      .halt_seen_i(halt_seen), .stop_i(stop), .drive_ready_i(drive_ready),
      .ext_stop_i(ext_stop),
      .cmd_ready_o(cmd_ready), .done_o(done), .refused_o(refused));
   pjt_monitor u_pjt_monitor (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .module_ready_flag(u_pjt_if.module_ready_flag),
      .x_axis_busy_flag(u_pjt_if.x_axis_busy_flag),
      .x_positioning_started_flag(u_pjt_if.x_positioning_started_flag),
      .x_aux_code_active_flag(u_pjt_if.x_aux_code_active_flag),
      .x_axis_stop_request(u_pjt_if.x_axis_stop_request),
      .host_ready_request(u_pjt_if.host_ready_request),
      .bm_wr(u_pjt_if.bm_wr), .bm_addr(u_pjt_if.bm_addr), .bm_wdata(u_pjt_if.bm_wdata));

   always #12.5 ref_clk_i = ~ref_clk_i;

   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge ref_clk_i) begin
      cycles++;
      // Whole run needs a few hundred cycles
      if (cycles == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Result is {done, refused}
   task automatic run_cmd(input pjt_pkg::pjt_cmd_t c, input logic [15:0] a,
                          output logic [1:0] res);
      int n;
      @(negedge ref_clk_i);
      cmd = c;
      arg = a;
      cmd_valid = 1'b1;
      @(negedge ref_clk_i);
      cmd_valid = 1'b0;
      res = 2'b00;
      for (n = 0; n < 20 && res == 2'b00; n++) begin
         @(negedge ref_clk_i);
         res = {done, refused};
      end
   endtask : run_cmd

   task automatic pulse_x;
      @(negedge ref_clk_i);
      pulser[0] = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      pulser[0] = 1'b0;
   endtask : pulse_x

   task automatic t_reset;
      check({15'h0000, u_pjt_if.module_ready_flag}, 16'h0001);
      check({15'h0000, u_pjt_if.x_axis_busy_flag}, 16'h0000);
      check({15'h0000, cmd_ready}, 16'h0001);
      check({8'h00, err}, 16'h0000);
   endtask : t_reset

   task automatic t_jog;
      logic [1:0] r;
      run_cmd(pjt_pkg::CMD_SETUP, 16'h0100, r);
      check({14'h0000, r}, 16'h0002);
      run_cmd(pjt_pkg::CMD_JOG, 16'h0010, r);
      check({14'h0000, r}, 16'h0001);
      run_cmd(pjt_pkg::CMD_JOG, 16'h0080, r);
      repeat (3) @(negedge ref_clk_i);
      check(jog_speed[0], 16'h0080);
      run_cmd(pjt_pkg::CMD_JOG, 16'h0500, r);
      repeat (3) @(negedge ref_clk_i);
      check(jog_speed[0], 16'h0100);
   endtask : t_jog

   task automatic t_refusals;
      logic [1:0] r;
      for (int k = 0; k < 6; k++) begin
         @(negedge ref_clk_i);
         case (k)
            0: stop = 2'h1;
            1: pos_started = 2'h1;
            2: aux = 2'h1;
            3: drive_ready = 1'b0;
            4: motion_busy = 2'h1;
            default: ext_stop = 1'b1;
         endcase
         repeat (4) @(negedge ref_clk_i);
         run_cmd(pjt_pkg::CMD_INCH_ON, 16'hFFFF, r);
         check({14'h0000, r}, 16'h0001);
         stop = 2'h0;
         pos_started = 2'h0;
         aux = 2'h0;
         drive_ready = 1'b1;
         motion_busy = 2'h0;
         ext_stop = 1'b0;
         repeat (4) @(negedge ref_clk_i);
      end
   endtask : t_refusals

   task automatic t_inch_steps;
      logic [1:0] r;
      int n;
      int steps;
      run_cmd(pjt_pkg::CMD_INCH_ON, 16'hFFFF, r);
      check({14'h0000, r}, 16'h0002);
      pulse_x();
      for (n = 0; n < 10 && !u_pjt_if.x_axis_busy_flag; n++) @(negedge ref_clk_i);
      check({15'h0000, u_pjt_if.x_axis_busy_flag}, 16'h0001);
      steps = 0;
      // One step per counted pulse, busy drops with it
      for (n = 0; n < 500 && u_pjt_if.x_axis_busy_flag; n++) begin
         @(negedge ref_clk_i);
         if (step[0] === 1'b1) steps++;
      end
      check(16'(steps), 16'h0001);
   endtask : t_inch_steps

   task automatic t_store;
      logic [1:0] r;
      run_cmd(pjt_pkg::CMD_STORE, 16'h0000, r);
      check({14'h0000, r}, 16'h0002);
   endtask : t_store

   task automatic t_inch_off;
      logic [1:0] r;
      run_cmd(pjt_pkg::CMD_INCH_OFF, 16'h0000, r);
      pulse_x();
      repeat (8) @(negedge ref_clk_i);
      check({15'h0000, u_pjt_if.x_axis_busy_flag}, 16'h0000);
      check({8'h00, err}, 16'h0000);
   endtask : t_inch_off

   task automatic t_busy_error;
      logic [1:0] r;
      run_cmd(pjt_pkg::CMD_INCH_ON, 16'hFFFF, r);
      @(negedge ref_clk_i);
      motion_busy = 2'h1;
      pulse_x();
      repeat (6) @(negedge ref_clk_i);
      check({8'h00, err}, {8'h00, pjt_pkg::ERR_PULSER_BUSY});
      motion_busy = 2'h0;
      run_cmd(pjt_pkg::CMD_INCH_OFF, 16'h0000, r);
      check({14'h0000, r}, 16'h0002);
   endtask : t_busy_error

   // Halt interlock, then a mid-run reset leaves host ready low for the test-mode bypass
   task automatic t_halt_test;
      logic [1:0] r;
      @(negedge ref_clk_i);
      halt_seen = 1'b1;
      motion_busy = 2'h2;
      repeat (4) @(negedge ref_clk_i);
      run_cmd(pjt_pkg::CMD_INCH_ON, 16'hFFFF, r);
      check({14'h0000, r}, 16'h0001);
      run_cmd(pjt_pkg::CMD_JOG, 16'h0040, r);
      check({14'h0000, r}, 16'h0001);
      motion_busy = 2'h0;
      repeat (4) @(negedge ref_clk_i);
      run_cmd(pjt_pkg::CMD_JOG, 16'h0040, r);
      check({14'h0000, r}, 16'h0002);
      halt_seen = 1'b0;
      rst_i = 1'b1;
      repeat (6) @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      t_reset();
      run_cmd(pjt_pkg::CMD_JOG, 16'h0040, r);
      check({14'h0000, r}, 16'h0001);
      test_mode = 1'b1;
      run_cmd(pjt_pkg::CMD_JOG, 16'h0040, r);
      check({14'h0000, r}, 16'h0002);
      test_mode = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      check(jog_speed[0], 16'h0040);
   endtask : t_halt_test

   initial begin
      repeat (6) @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      t_reset();
      t_jog();
      t_refusals();
      t_inch_steps();
      t_store();
      t_inch_off();
      t_busy_error();
      t_halt_test();
      report_and_stop();
   end
endmodule : pulser_jog_teach_interlock_tb_top
`default_nettype wire
